/* hw/ttc_timers.sv */
// Three timer/counters behind the core's special function registers
`timescale 1ns/1ps
module ttc_timers (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [3:0] sfrSel,
  input wire logic sfrWrEn,
  input wire logic [7:0] sfrWdata,
  output logic [7:0] sfrRdata,
  input wire logic ackTimer0,
  input wire logic ackTimer1,
  input wire logic ackExtIrq0,
  input wire logic ackExtIrq1,
  input wire logic rx2BaudFromTimer2,
  input wire logic tx2BaudFromTimer2,
  input wire logic timer0EventPin,
  input wire logic timer1EventPin,
  input wire logic extIrq0Pin,
  input wire logic extIrq1Pin,
  input wire logic timer2EventPin,
  input wire logic timer2TriggerPin,
  output logic [7:0] runFlagCtl,
  output logic [7:0] timer2Ctl,
  output logic timer1OvfPulse,
  output logic timer2OvfPulse
);
  typedef struct packed {
    logic [2:0] mc;
    logic [5:0] sync1;
    logic [5:0] sync2;
    logic [5:0] samp;
    logic [2:0] pend;
    logic [1:0] irqPrev;
    logic [7:0] ctl;
    logic [7:0] modeSel;
    logic [1:0][7:0] lowByte;
    logic [1:0][7:0] highByte;
    logic [7:0] t2Ctl;
    logic [7:0] t2Low;
    logic [7:0] t2High;
    logic [7:0] capLow;
    logic [7:0] capHigh;
    logic [7:0] rdata;
    logic t1Ovf;
    logic t2Ovf;
  } ttc_state_t;

  localparam ttc_state_t RESET_STATE = '{sync1: ttc_pkg::PIN_IDLE, sync2: ttc_pkg::PIN_IDLE,
    samp: ttc_pkg::PIN_IDLE, irqPrev: ttc_pkg::IRQ_IDLE, default: '0};

  ttc_state_t q;
  ttc_state_t d;
  logic [5:0] pinsIn;
  logic mcEn;
  logic [2:0] evt;
  logic [1:0] ovf;
  logic [1:0] md;
  logic run;
  logic cnt;
  logic t0Split;
  logic thOvf;
  logic [13:0] c13;
  logic [16:0] c17;
  logic [8:0] c9;
  logic baud;
  logic capture;
  logic trig;
  logic inc2;
  logic ovf2;
  logic [1:0] xFall;

  assign pinsIn = {timer2TriggerPin, timer2EventPin, extIrq1Pin, extIrq0Pin,
                   timer1EventPin, timer0EventPin};
  assign mcEn = (q.mc == ttc_pkg::MC_LAST);
  assign evt = q.pend & {3{mcEn}};
  assign t0Split = (q.modeSel[1:0] == ttc_pkg::MODE_SPLIT);
  assign baud = q.t2Ctl[ttc_pkg::RX_BAUD_B] | q.t2Ctl[ttc_pkg::TX_BAUD_B]
              | rx2BaudFromTimer2 | tx2BaudFromTimer2;
  assign capture = ~baud & q.t2Ctl[ttc_pkg::T2_CAP_B];
  assign trig = mcEn & q.samp[ttc_pkg::P_TRIG] & ~q.sync2[ttc_pkg::P_TRIG]
              & q.t2Ctl[ttc_pkg::T2_TRIG_EN_B];
  assign xFall = q.irqPrev & ~q.sync2[ttc_pkg::P_IRQ1:ttc_pkg::P_IRQ0];

  always_comb
  begin
    d = q;
    ovf = 2'b00;
    md = 2'b00;
    run = 1'b0;
    cnt = 1'b0;
    thOvf = 1'b0;
    c13 = 14'h0;
    c17 = 17'h0;
    c9 = 9'h0;
    d.mc = mcEn ? 3'h0 : q.mc + 3'h1;
    // Only the second stage is read by logic
    d.sync1 = pinsIn;
    d.sync2 = q.sync1;
    d.irqPrev = q.sync2[ttc_pkg::P_IRQ1:ttc_pkg::P_IRQ0];
    if (mcEn)
    begin
      // One sample per machine cycle; a pulse shorter than that may be missed
      d.samp = q.sync2;
      d.pend[0] = q.samp[ttc_pkg::P_EV0] & ~q.sync2[ttc_pkg::P_EV0];
      d.pend[1] = q.samp[ttc_pkg::P_EV1] & ~q.sync2[ttc_pkg::P_EV1];
      d.pend[2] = q.samp[ttc_pkg::P_EV2] & ~q.sync2[ttc_pkg::P_EV2];
    end

    for (int i = 0; i < 2; i++)
    begin
      md = q.modeSel[4*i +: 2];
      cnt = q.modeSel[4*i+2] ? evt[i] : mcEn;
      run = q.ctl[ttc_pkg::T0_RUN_B+2*i]
          & (~q.modeSel[4*i+3] | q.sync2[ttc_pkg::P_IRQ0+i]);
      if (i == 1 && t0Split)
      begin
        // Run bit lent to the split high byte; only mode 11 or the gate with extIrq1 low stops timer 1
        run = ~q.modeSel[7] | q.sync2[ttc_pkg::P_IRQ1];
      end
      if (i == 1 && md == ttc_pkg::MODE_SPLIT)
      begin
        run = 1'b0;
      end
      if (run && cnt)
      begin
        case (md)
          ttc_pkg::MODE_13:
          begin
            c13 = {1'b0, q.highByte[i], q.lowByte[i][4:0]} + 14'h1;
            d.highByte[i] = c13[12:5];
            d.lowByte[i][4:0] = c13[4:0];
            ovf[i] = c13[13];
          end
          ttc_pkg::MODE_16:
          begin
            c17 = {1'b0, q.highByte[i], q.lowByte[i]} + 17'h1;
            d.highByte[i] = c17[15:8];
            d.lowByte[i] = c17[7:0];
            ovf[i] = c17[16];
          end
          ttc_pkg::MODE_RELOAD:
          begin
            c9 = {1'b0, q.lowByte[i]} + 9'h1;
            d.lowByte[i] = c9[8] ? q.highByte[i] : c9[7:0];
            ovf[i] = c9[8];
          end
          default:
          begin
            c9 = {1'b0, q.lowByte[i]} + 9'h1;
            d.lowByte[i] = c9[7:0];
            ovf[i] = c9[8];
          end
        endcase
      end
    end
    if (t0Split && mcEn && q.ctl[ttc_pkg::T1_RUN_B])
    begin
      c9 = {1'b0, q.highByte[0]} + 9'h1;
      d.highByte[0] = c9[7:0];
      thOvf = c9[8];
    end

    inc2 = q.t2Ctl[ttc_pkg::T2_RUN_B]
         & (q.t2Ctl[ttc_pkg::T2_EVT_B] ? evt[2] : mcEn);
    c17 = {1'b0, q.t2High, q.t2Low} + 17'h1;
    ovf2 = inc2 & c17[16];
    if (inc2)
    begin
      {d.t2High, d.t2Low} = c17[15:0];
    end
    if (ovf2 && !capture)
    begin
      {d.t2High, d.t2Low} = {q.capHigh, q.capLow};
    end
    if (trig && !baud)
    begin
      if (capture)
      begin
        {d.capHigh, d.capLow} = {q.t2High, q.t2Low};
      end
      else
      begin
        {d.t2High, d.t2Low} = {q.capHigh, q.capLow};
      end
    end

    // Vector acknowledge or a write clears; a level-type request flag ignores both and clears only when its pin goes high
    if (ackTimer0)
    begin
      d.ctl[ttc_pkg::T0_OVF_B] = 1'b0;
    end
    if (ackTimer1)
    begin
      d.ctl[ttc_pkg::T1_OVF_B] = 1'b0;
    end
    if (ackExtIrq0)
    begin
      d.ctl[ttc_pkg::X0_FLAG_B] = 1'b0;
    end
    if (ackExtIrq1)
    begin
      d.ctl[ttc_pkg::X1_FLAG_B] = 1'b0;
    end

    // Writes land after the count and acknowledge updates so they take precedence over those
    if (sfrWrEn)
    begin
      case (sfrSel)
        ttc_pkg::SEL_CTL: d.ctl = sfrWdata;
        ttc_pkg::SEL_MODE: d.modeSel = sfrWdata;
        ttc_pkg::SEL_LOW0: d.lowByte[0] = sfrWdata;
        ttc_pkg::SEL_HIGH0: d.highByte[0] = sfrWdata;
        ttc_pkg::SEL_LOW1: d.lowByte[1] = sfrWdata;
        ttc_pkg::SEL_HIGH1: d.highByte[1] = sfrWdata;
        ttc_pkg::SEL_T2CTL: d.t2Ctl = sfrWdata;
        ttc_pkg::SEL_T2LOW: d.t2Low = sfrWdata;
        ttc_pkg::SEL_T2HIGH: d.t2High = sfrWdata;
        ttc_pkg::SEL_CAPLOW: d.capLow = sfrWdata;
        ttc_pkg::SEL_CAPHIGH: d.capHigh = sfrWdata;
        default: d.rdata = q.rdata;
      endcase
    end

    // Level-type requests track the pin; edge-type ones latch a fall
    for (int k = 0; k < 2; k++)
    begin
      if (!q.ctl[ttc_pkg::X0_TYPE_B+2*k])
      begin
        d.ctl[ttc_pkg::X0_FLAG_B+2*k] = ~q.sync2[ttc_pkg::P_IRQ0+k];
      end
      else if (xFall[k])
      begin
        d.ctl[ttc_pkg::X0_FLAG_B+2*k] = 1'b1;
      end
    end
    // Hardware sets win over a same-cycle clear or write
    if (ovf[0])
    begin
      d.ctl[ttc_pkg::T0_OVF_B] = 1'b1;
    end
    if (t0Split ? thOvf : ovf[1])
    begin
      d.ctl[ttc_pkg::T1_OVF_B] = 1'b1;
    end
    if (ovf2 && !baud)
    begin
      d.t2Ctl[ttc_pkg::T2_OVF_B] = 1'b1;
    end
    if (trig)
    begin
      d.t2Ctl[ttc_pkg::T2_TRIG_FLAG_B] = 1'b1;
    end
    d.t1Ovf = ovf[1];
    d.t2Ovf = ovf2;

    case (sfrSel)
      ttc_pkg::SEL_CTL: d.rdata = q.ctl;
      ttc_pkg::SEL_MODE: d.rdata = q.modeSel;
      ttc_pkg::SEL_LOW0: d.rdata = q.lowByte[0];
      ttc_pkg::SEL_HIGH0: d.rdata = q.highByte[0];
      ttc_pkg::SEL_LOW1: d.rdata = q.lowByte[1];
      ttc_pkg::SEL_HIGH1: d.rdata = q.highByte[1];
      ttc_pkg::SEL_T2CTL: d.rdata = q.t2Ctl;
      ttc_pkg::SEL_T2LOW: d.rdata = q.t2Low;
      ttc_pkg::SEL_T2HIGH: d.rdata = q.t2High;
      ttc_pkg::SEL_CAPLOW: d.rdata = q.capLow;
      ttc_pkg::SEL_CAPHIGH: d.rdata = q.capHigh;
      default: d.rdata = ttc_pkg::RESET_BYTE;
    endcase
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      q <= RESET_STATE;
    end
    else
    begin
      q <= d;
    end
  end

  assign sfrRdata = q.rdata;
  assign runFlagCtl = q.ctl;
  assign timer2Ctl = q.t2Ctl;
  assign timer1OvfPulse = q.t1Ovf;
  assign timer2OvfPulse = q.t2Ovf;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);

  mc_period_a: assert property (mcEn |=> !mcEn [*5] ##1 mcEn)
    else $error("machine cycle is not six clocks");
  t0_rate_a: assert property (mcEn && q.modeSel[3:0] == 4'h1 && q.ctl[4] && !sfrWrEn
    |=> {q.highByte[0], q.lowByte[0]} == $past({q.highByte[0], q.lowByte[0]}) + 16'h1)
    else $error("timer 0 did not advance");
  edge_delay_a: assert property (mcEn && q.samp[0] && !q.sync2[0]
    |=> q.pend[0] ##5 (mcEn && q.pend[0]))
    else $error("event edge not counted one machine cycle later");
  gate_hold_a: assert property (q.modeSel[3] && !q.sync2[2] && !sfrWrEn && !t0Split
    |=> $stable({q.highByte[0], q.lowByte[0]}))
    else $error("gated timer 0 counted");
  ovf_flag_a: assert property (ovf[0] |=> q.ctl[5])
    else $error("overflow flag not set");
  reload8_a: assert property (ovf[0] && q.modeSel[1:0] == 2'h2 && !sfrWrEn
    |=> q.lowByte[0] == $past(q.highByte[0]))
    else $error("low byte not reloaded");
  t1_stop_a: assert property (q.modeSel[5:4] == 2'h3 && !sfrWrEn
    |=> $stable({q.highByte[1], q.lowByte[1]}))
    else $error("timer 1 counted in mode 11");
  baud_noflag_a: assert property (baud && !q.t2Ctl[7] && !sfrWrEn |=> !q.t2Ctl[7])
    else $error("timer 2 flag set in baud mode");
  capture_copy_a: assert property (trig && capture && !sfrWrEn
    |=> {q.capHigh, q.capLow} == $past({q.t2High, q.t2Low}) && q.t2Ctl[6])
    else $error("capture did not copy count");
  write_wins_a: assert property (sfrWrEn && sfrSel == 4'h2
    |=> q.lowByte[0] == $past(sfrWdata))
    else $error("write lost to increment");

  split_c: cover property (t0Split && thOvf);
  capture_c: cover property (trig && capture);
  reload_c: cover property (ovf2 && !capture);
  event_c: cover property (evt[0] && q.modeSel[2]);
endmodule : ttc_timers

/* pkg/ttc_pkg.sv */
// Constants for the three-timer counter unit
package ttc_pkg;
  localparam logic [2:0] MC_LAST = 3'h5;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  // Pins idle high; sampling stages start there so reset shows no false fall
  localparam logic [5:0] PIN_IDLE = 6'h3f;
  localparam logic [1:0] IRQ_IDLE = 2'h3;
  localparam int T1_OVF_B = 7;
  localparam int T1_RUN_B = 6;
  localparam int T0_OVF_B = 5;
  localparam int T0_RUN_B = 4;
  localparam int X1_FLAG_B = 3;
  localparam int X1_TYPE_B = 2;
  localparam int X0_FLAG_B = 1;
  localparam int X0_TYPE_B = 0;
  localparam int T2_OVF_B = 7;
  localparam int T2_TRIG_FLAG_B = 6;
  localparam int RX_BAUD_B = 5;
  localparam int TX_BAUD_B = 4;
  localparam int T2_TRIG_EN_B = 3;
  localparam int T2_RUN_B = 2;
  localparam int T2_EVT_B = 1;
  localparam int T2_CAP_B = 0;
  localparam logic [1:0] MODE_13 = 2'h0;
  localparam logic [1:0] MODE_16 = 2'h1;
  localparam logic [1:0] MODE_RELOAD = 2'h2;
  localparam logic [1:0] MODE_SPLIT = 2'h3;
  localparam logic [3:0] SEL_CTL = 4'h0;
  localparam logic [3:0] SEL_MODE = 4'h1;
  localparam logic [3:0] SEL_LOW0 = 4'h2;
  localparam logic [3:0] SEL_HIGH0 = 4'h3;
  localparam logic [3:0] SEL_LOW1 = 4'h4;
  localparam logic [3:0] SEL_HIGH1 = 4'h5;
  localparam logic [3:0] SEL_T2CTL = 4'h6;
  localparam logic [3:0] SEL_T2LOW = 4'h7;
  localparam logic [3:0] SEL_T2HIGH = 4'h8;
  localparam logic [3:0] SEL_CAPLOW = 4'h9;
  localparam logic [3:0] SEL_CAPHIGH = 4'ha;
  localparam int P_EV0 = 0;
  localparam int P_EV1 = 1;
  localparam int P_IRQ0 = 2;
  localparam int P_IRQ1 = 3;
  localparam int P_EV2 = 4;
  localparam int P_TRIG = 5;
endpackage : ttc_pkg

/* tb/ttc_event_src.sv */
// Event pin source standing in for the outside world
`timescale 1ns/1ps
module ttc_event_src (
  input wire logic mclk,
  output logic evPin
);
  initial evPin = 1'b1;

  // Each level held for hold clocks; six or more gives every level at least one sample
  task automatic pulses(input int n, input int hold);
    repeat (n)
    begin
      repeat (hold) @(posedge mclk);
      #1 evPin = 1'b0;
      repeat (hold) @(posedge mclk);
      #1 evPin = 1'b1;
    end
  endtask : pulses
endmodule : ttc_event_src

/* tb/tb_top.sv */
// Self-checking bench for the three-timer counter unit
`timescale 1ns/1ps
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin mismatches++; \
  $display("mismatch at %0t: got %h exp %h", $time, got, exp); end end
module tb_top;
  typedef struct packed {logic [3:0] sel; logic [7:0] wd; logic [7:0] ex;} ttc_row_t;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic [3:0] sfrSel = 4'h0;
  logic sfrWrEn = 1'b0;
  logic [7:0] sfrWdata = 8'h00;
  logic [7:0] sfrRdata;
  logic [3:0] ack = 4'h0;
  logic rx2Baud = 1'b0;
  logic tx2Baud = 1'b0;
  logic extIrq0Pin = 1'b1;
  logic extIrq1Pin = 1'b1;
  logic trigPin = 1'b1;
  logic ev1Pin;
  logic [7:0] runFlagCtl;
  logic [7:0] timer2Ctl;
  logic t1Pulse;
  logic t2Pulse;
  logic t1Seen = 1'b0;
  logic t2Seen = 1'b0;
  logic [15:0] fl;
  int mismatches = 0;
  int checks = 0;
  // Unmapped select b must read back zero
  ttc_row_t rows [12] = '{'{4'h0, 8'h05, 8'h05}, '{4'h2, 8'h5a, 8'h5a}, '{4'h3, 8'hc3, 8'hc3},
    '{4'h4, 8'h3c, 8'h3c}, '{4'h5, 8'h96, 8'h96}, '{4'h6, 8'h01, 8'h01}, '{4'h7, 8'h11, 8'h11},
    '{4'h8, 8'h22, 8'h22}, '{4'h9, 8'h33, 8'h33}, '{4'ha, 8'h44, 8'h44}, '{4'hb, 8'h77, 8'h00},
    '{4'h1, 8'ha5, 8'ha5}};

  assign fl = {timer2Ctl, runFlagCtl};
  always #4 mclk = ~mclk;

  always @(posedge mclk)
  begin
    if (t1Pulse === 1'b1)
      t1Seen <= 1'b1;
    if (t2Pulse === 1'b1)
      t2Seen <= 1'b1;
  end

  ttc_timers ttc_timers_inst (.mclk(mclk), .reset_n(reset_n), .sfrSel(sfrSel),
    .sfrWrEn(sfrWrEn), .sfrWdata(sfrWdata), .sfrRdata(sfrRdata), .ackTimer0(ack[0]),
    .ackTimer1(ack[1]), .ackExtIrq0(ack[2]), .ackExtIrq1(ack[3]),
    .rx2BaudFromTimer2(rx2Baud), .tx2BaudFromTimer2(tx2Baud), .timer0EventPin(ev1Pin),
    .timer1EventPin(ev1Pin), .extIrq0Pin(extIrq0Pin), .extIrq1Pin(extIrq1Pin),
    .timer2EventPin(ev1Pin), .timer2TriggerPin(trigPin), .runFlagCtl(runFlagCtl),
    .timer2Ctl(timer2Ctl), .timer1OvfPulse(t1Pulse), .timer2OvfPulse(t2Pulse));

  ttc_event_src ttc_event_src_inst (.mclk(mclk), .evPin(ev1Pin));

  task automatic final_report();
    if (mismatches == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : final_report

  task automatic idle(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : idle

  // One idle edge first so back-to-back writes never retoggle the strobe
  task automatic wr(input logic [3:0] s, input logic [7:0] d);
    idle(1);
    sfrSel = s;
    sfrWdata = d;
    sfrWrEn = 1'b1;
    idle(1);
    sfrWrEn = 1'b0;
  endtask : wr

  task automatic rdc(input logic [3:0] s, input logic [7:0] e);
    sfrSel = s;
    idle(1);
    `CHK(sfrRdata, e)
  endtask : rdc

  // Run window of exactly 60 clocks, ten machine cycles whatever the phase
  task automatic win(input logic [3:0] s, input logic [7:0] on, input int mi, input logic me);
    wr(s, on);
    idle(29);
    if (mi >= 0)
      `CHK(fl[mi], me)
    idle(29);
    wr(s, 8'h00);
  endtask : win

  task automatic wait_bit(input int i);
    int n;
    n = 0;
    while (fl[i] !== 1'b1 && n < 40)
    begin
      idle(1);
      n++;
    end
    `CHK(fl[i], 1'b1)
    if (fl[i] !== 1'b1)
      final_report();
  endtask : wait_bit

  task automatic ackp(input int i);
    ack[i] = 1'b1;
    idle(1);
    ack[i] = 1'b0;
    idle(2);
  endtask : ackp

  initial
  begin
    idle(8);
    reset_n = 1'b1;
    `CHK(runFlagCtl, 8'h00)
    `CHK(timer2Ctl, 8'h00)
    foreach (rows[i])
    begin
      wr(rows[i].sel, rows[i].wd);
      rdc(rows[i].sel, rows[i].ex);
    end
    wr(4'h1, 8'h01);
    wr(4'h2, 8'h00);
    wr(4'h3, 8'h00);
    win(4'h0, 8'h10, -1, 1'b0);
    rdc(4'h2, 8'h0a);
    rdc(4'h3, 8'h00);
    wr(4'h1, 8'h09);
    wr(4'h2, 8'h00);
    extIrq0Pin = 1'b0;
    idle(4);
    win(4'h0, 8'h10, -1, 1'b0);
    rdc(4'h2, 8'h00);
    extIrq0Pin = 1'b1;
    idle(4);
    win(4'h0, 8'h10, -1, 1'b0);
    rdc(4'h2, 8'h0a);
    wr(4'h1, 8'h02);
    wr(4'h2, 8'hfe);
    wr(4'h3, 8'hf0);
    win(4'h0, 8'h10, 5, 1'b1);
    rdc(4'h2, 8'hf8);
    rdc(4'h3, 8'hf0);
    // Single machine cycle: prescaler carries into the high byte
    wr(4'h1, 8'h00);
    wr(4'h2, 8'hff);
    wr(4'h3, 8'hff);
    wr(4'h0, 8'h10);
    idle(4);
    wr(4'h0, 8'h00);
    rdc(4'h2, 8'he0);
    rdc(4'h3, 8'h00);
    // One source feeds all three event pins
    wr(4'h1, 8'h55);
    wr(4'h4, 8'h00);
    wr(4'h6, 8'h06);
    wr(4'h0, 8'h50);
    ttc_event_src_inst.pulses(5, 12);
    ttc_event_src_inst.pulses(3, 6);
    idle(18);
    rdc(4'h4, 8'h08);
    rdc(4'h2, 8'he8);
    rdc(4'h7, 8'h19);
    wr(4'h1, 8'h30);
    win(4'h0, 8'h40, -1, 1'b0);
    rdc(4'h4, 8'h08);
    wr(4'h1, 8'h03);
    wr(4'h2, 8'h00);
    wr(4'h3, 8'hfe);
    wr(4'h5, 8'hff);
    wr(4'h4, 8'hff);
    t1Seen = 1'b0;
    win(4'h0, 8'h40, 7, 1'b1);
    rdc(4'h3, 8'h08);
    rdc(4'h2, 8'h00);
    `CHK(t1Seen, 1'b1)
    win(4'h0, 8'h10, -1, 1'b0);
    rdc(4'h2, 8'h0a);
    wr(4'h1, 8'h00);
    for (int i = 0; i < 2; i++)
    begin
      wr(4'h0, (i == 0) ? 8'h20 : 8'h80);
      ackp(i);
      `CHK(fl[5 + 2 * i], 1'b0)
    end
    wr(4'h0, 8'h01);
    extIrq0Pin = 1'b0;
    wait_bit(1);
    ackp(2);
    `CHK(fl[1], 1'b0)
    extIrq0Pin = 1'b1;
    wr(4'h9, 8'h34);
    wr(4'ha, 8'h12);
    // Any baud select forces reload and hides the overflow flag
    for (int b = 0; b < 5; b++)
    begin
      rx2Baud = (b == 1);
      tx2Baud = (b == 2);
      wr(4'h7, 8'hfe);
      wr(4'h8, 8'hff);
      t2Seen = 1'b0;
      win(4'h6, {2'b00, b == 3, b == 4, 4'h4}, 15, (b == 0));
      rdc(4'h7, 8'h3c);
      rdc(4'h8, 8'h12);
      `CHK(t2Seen, 1'b1)
    end
    rx2Baud = 1'b0;
    tx2Baud = 1'b0;
    wr(4'h7, 8'hcd);
    wr(4'h8, 8'hab);
    wr(4'h6, 8'h09);
    trigPin = 1'b0;
    wait_bit(14);
    rdc(4'h9, 8'hcd);
    rdc(4'ha, 8'hab);
    idle(12);
    `CHK(fl[14], 1'b1)
    trigPin = 1'b1;
    idle(8);
    wr(4'h7, 8'h00);
    wr(4'h8, 8'h00);
    wr(4'h6, 8'h08);
    trigPin = 1'b0;
    wait_bit(14);
    rdc(4'h7, 8'hcd);
    rdc(4'h8, 8'hab);
    final_report();
  end
endmodule : tb_top
